//--- flash_cmd_pkg.sv
// constants, types and command codes for the serial flash command block
// assumes one system clock at 10 MHz and a host-driven serial clock
package flash_cmd_pkg;

  // command opcodes
  localparam logic [7:0] OPC_FAST_READ = 8'h0b;
  localparam logic [7:0] OPC_DUAL_OUT  = 8'h3b;
  localparam logic [7:0] OPC_QUAD_OUT  = 8'h6b;
  localparam logic [7:0] OPC_DUAL_IO   = 8'hbb;
  localparam logic [7:0] OPC_QUAD_IO   = 8'heb;
  localparam logic [7:0] OPC_SET_WRAP  = 8'h77;
  localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
  localparam logic [7:0] OPC_WR_EN     = 8'h06;
  localparam logic [7:0] OPC_WR_DIS    = 8'h04;
  localparam logic [7:0] OPC_RD_STATUS = 8'h05;

  // clock counts inside a frame
  localparam logic [4:0] OPC_LAST   = 5'h07; // eighth opcode clock
  localparam logic [4:0] DUMMY_FAST = 5'h08; // single/dual/quad output
  localparam logic [4:0] DUMMY_IO   = 5'h04; // dual and quad i/o
  localparam logic [4:0] ADDR_BITS  = 5'h18; // 24 address bits

  // wrap setting {length[1:0], disable}; wrapping off after reset
  localparam logic [2:0] WRAP_RESET = 3'h1;
  localparam int         WRAP_DIS   = 0;
  localparam logic [23:0] WRAP_MIN  = 24'h000008; // 8-byte section

  // status byte positions
  localparam int SR_BUSY_BIT = 0;
  localparam int SR_WEL_BIT  = 1;

  // storage and page
  localparam int MEM_ADDR_BITS = 12;
  localparam int PAGE_BYTES    = 256;

  // protection sizes as address exponents
  localparam logic [4:0] PROT_SEC_BASE = 5'h0b; // 4 KB at range 1
  localparam logic [4:0] PROT_BLK_BASE = 5'h0f; // 64 KB at range 1
  localparam logic [2:0] PROT_SEC_MAX  = 3'h5;  // 64 KB ceiling

  // program cycle time
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS  = 400000;
  localparam int PROG_CYCLES   =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // what a finished frame asks of the core
  typedef enum logic [2:0] {
    RES_NONE = 3'h0,
    RES_WREN = 3'h1,
    RES_WRDI = 3'h2,
    RES_PROG = 3'h3,
    RES_WRAP = 3'h4
  } frame_res_t;

  // link phases, one-hot
  typedef enum logic [7:0] {
    PH_OPC    = 8'h01,
    PH_ADDR   = 8'h02,
    PH_DUMMY  = 8'h04,
    PH_DATA   = 8'h08,
    PH_STAT   = 8'h10,
    PH_PROG   = 8'h20,
    PH_WRAPB  = 8'h40,
    PH_IGNORE = 8'h80
  } link_phase_t;

  // core states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_PROG = 2'h2
  } core_state_t;

endpackage

//--- pin_sync3.sv
// three-stage synchroniser; a bit changes once stages two and three agree
// assumes the input is quasi-static or a level from another domain
`timescale 1ns/1ns
module pin_sync3 #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_reg; // first stage, read only by s2
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // shift chain and per-bit agreement filter
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q_out  <= INIT;
    end else if (ce_in) begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // keep old value on bits that still disagree
      q_out  <= (s2_reg & ~(s2_reg ^ s3_reg)) | (q_out & (s2_reg ^ s3_reg));
    end
  end
endmodule

//--- flash_cmd_core.sv
// serial flash command block: fast reads, wrap setup, page program
// assumes a host on chip select / serial clock, mode 0, 1-4 data lines
//
// Functional notes
// RULE1: fast read: address, eight dummies, then data
// RULE2: dual output read drives two lines
// RULE3: host frees line 0 before data
// RULE4: quad output read only with quad enable
// RULE5: host frees all lines before data
// RULE6: dual i/o: address and data two-wide
// RULE7: quad i/o: four-wide, four dummy clocks
// RULE8: wrap setup: 24 dummies, then setting byte
// RULE9: disable bit and length pick section
// RULE10: wrapped read loops within its section
// RULE11: wrap setting persists until next setup
// RULE12: wrapping disabled after any reset
// RULE13: program accepted only with latch set
// RULE14: page address wraps, later bytes overwrite
// RULE15: host keeps full pages page-aligned
// RULE16: program needs chip select on byte boundary
// RULE17: busy high through self-timed program
// RULE18: status readable while busy
// RULE19: latch cleared when program ends
// RULE20: protected pages are not programmed
// RULE21: msb first, address increments per byte
// RULE22: reads ignored while busy
// RULE23: write enable sets the latch
// RULE24: higher line carries more significant bits
// RULE25: quad i/o also needs quad enable
`timescale 1ns/1ns
module flash_cmd_core
  import flash_cmd_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic         ce_in,
  input  wire logic         sck_in,      // link clock from host
  input  wire logic         cs_n_in,
  input  wire logic         data_line_0_in,
  output logic              data_line_0_out,
  output logic              data_line_0_oe_out,
  input  wire logic         data_line_1_in,
  output logic              data_line_1_out,
  output logic              data_line_1_oe_out,
  input  wire logic         data_line_2_in,
  output logic              data_line_2_out,
  output logic              data_line_2_oe_out,
  input  wire logic         data_line_3_in,
  output logic              data_line_3_out,
  output logic              data_line_3_oe_out,
  input  wire logic         quad_enable_bit_in,
  input  wire logic         protect_complement_bit_in,
  input  wire logic         protect_granularity_bit_in,
  input  wire logic         protect_top_bottom_bit_in,
  input  wire logic         protect_range_bit2_in,
  input  wire logic         protect_range_bit1_in,
  input  wire logic         protect_range_bit0_in,
  input  wire logic [255:0] block_lock_in, // one bit per 64 KB block
  output logic              busy_out,
  output logic              write_enable_latch_out,
  output logic              wrap_disable_bit_out,
  output logic [1:0]        wrap_length_field_out
);

  // lane helpers: shift_in for the address path, last_beat for the data path
  function automatic logic [23:0] shift_in(input logic [23:0] sh,
                                           input logic [3:0] io,
                                           input logic [2:0] l);
    unique case (l)
      3'h2:    return {sh[21:0], io[1:0]};
      3'h4:    return {sh[19:0], io};
      default: return {sh[22:0], io[0]};
    endcase
  endfunction

  function automatic logic [2:0] last_beat(input logic [2:0] l);
    unique case (l)
      3'h2:    return 3'h3;
      3'h4:    return 3'h1;
      default: return 3'h7;
    endcase
  endfunction

  // byte drive: msb first, upper bits on higher lines
  function automatic logic [7:0] out_bits(input logic [7:0] b,
                                          input logic [2:0] k,
                                          input logic [2:0] l);
    logic [7:0] sb;
    sb = b << (k * l);
    unique case (l)
      3'h2:    return {4'h3, 2'h0, sb[7:6]};
      3'h4:    return {4'hf, sb[7:4]};
      default: return {4'h2, 2'h0, sb[7], 1'h0}; // single out on line 1
    endcase
  endfunction

  // next read address, wrapped inside the section when asked
  function automatic logic [23:0] next_addr(input logic [23:0] a,
                                            input logic wrap_en,
                                            input logic [1:0] len);
    logic [23:0] m;
    logic [23:0] inc;
    m   = (WRAP_MIN << len) - 24'h1;
    inc = a + 24'h1;
    return wrap_en ? ((a & ~m) | (inc & m)) : inc;
  endfunction

  // block protection of a page
  function automatic logic is_protected(input logic [15:0] pg,
                                        input logic cmp, sec, tb,
                                        input logic [2:0] bp);
    logic [23:0] hi;
    logic [4:0]  e;
    logic        r;
    e  = sec ? PROT_SEC_BASE + 5'((bp > PROT_SEC_MAX) ? PROT_SEC_MAX : bp)
             : PROT_BLK_BASE + 5'(bp);
    hi = {pg, 8'h00} >> e;
    if (bp == 3'h0) r = 1'b0;
    else if (!sec && bp == 3'h7) r = 1'b1;
    else r = tb ? (hi == 24'h0) : (hi == (24'hffffff >> e));
    return r ^ cmp;
  endfunction

  logic [7:0]  mem [2**MEM_ADDR_BITS];  // backing array, aliased
  logic [7:0]  pbuf [PAGE_BYTES];       // page being collected
  logic [255:0] pmask_reg;              // bytes received this frame

  // link domain state
  logic        live_reg;    // cleared while chip select is high
  link_phase_t phase_reg;
  logic [7:0]  cmd_reg;
  logic [23:0] sh_reg;
  logic [4:0]  cnt_reg;
  logic [4:0]  alast_reg;   // last address clock
  logic [4:0]  dlast_reg;   // last dummy clock
  logic [2:0]  alanes_reg;
  logic [2:0]  lanes_reg;
  logic [2:0]  beat_reg;
  logic [23:0] addr_reg;
  logic [7:0]  pidx_reg;
  logic [7:0]  stat_reg;
  logic [2:0]  wrapb_reg;
  frame_res_t  res_reg;     // what chip select rising would commit
  logic        tog_reg;     // flips once per frame
  logic [3:0]  out_reg;
  logic [3:0]  oe_reg;
  logic [10:0] lk1_reg;     // first sync stage, read only by lk2
  logic [10:0] lk2_reg;

  // core domain state
  core_state_t st_reg;
  logic        busy_reg;
  logic        wel_reg;
  logic [2:0]  wrap_reg;
  logic [15:0] cnt_core_reg;
  logic [15:0] ppage_reg;
  logic        cs_prev_reg;
  logic        tog_seen_reg;

  logic [3:0]  io_in;
  logic [7:0]  op;
  logic [23:0] sh_next;
  logic        busy_s, wel_s, qe_s;
  logic [2:0]  wrap_s;
  logic [4:0]  prot_s;

  assign io_in = {data_line_3_in, data_line_2_in,
                  data_line_1_in, data_line_0_in};
  assign op      = {sh_reg[6:0], io_in[0]};
  assign sh_next = shift_in(sh_reg, io_in, alanes_reg);
  assign {busy_s, wel_s, qe_s, wrap_s, prot_s} = lk2_reg;

  // core flags into the link domain; only settle while sck runs
  always_ff @(posedge sck_in) begin
    lk1_reg <= {busy_reg, wel_reg, quad_enable_bit_in, wrap_reg,
                protect_granularity_bit_in, protect_top_bottom_bit_in,
                protect_range_bit2_in, protect_range_bit1_in,
                protect_range_bit0_in};
    lk2_reg <= lk1_reg;
  end

  // frame start marker, cleared at once by chip select
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) live_reg <= 1'b0;
    else live_reg <= 1'b1;
  end

  // frame marker and commit code; must survive chip select rising
  always_ff @(posedge sck_in or posedge srst_in) begin
    if (srst_in) begin
      tog_reg <= 1'b0;
      res_reg <= RES_NONE;
    end else if (!live_reg) begin
      tog_reg <= ~tog_reg;
      res_reg <= RES_NONE;
    end else if (phase_reg == PH_OPC && cnt_reg == OPC_LAST) begin
      // write enable/disable only valid after exactly eight bits
      if (op == OPC_WR_EN) res_reg <= RES_WREN; // see RULE23
      else if (op == OPC_WR_DIS) res_reg <= RES_WRDI;
      else res_reg <= RES_NONE;
    end else if (phase_reg == PH_PROG && beat_reg == 3'h7) begin
      res_reg <= RES_PROG; // see RULE16
    end else if (phase_reg == PH_WRAPB && cnt_reg == OPC_LAST) begin
      res_reg <= RES_WRAP; // see RULE8
    end else begin
      res_reg <= RES_NONE; // stray bits void the commit, see RULE16
    end
  end

  // command sequencer on rising sck
  always_ff @(posedge sck_in) begin
    if (!live_reg) begin
      phase_reg <= PH_OPC;
      cnt_reg   <= 5'h1;
      sh_reg    <= {23'h0, io_in[0]};
    end else begin
      unique case (phase_reg)
        PH_OPC: begin
          sh_reg  <= {sh_reg[22:0], io_in[0]};
          cnt_reg <= cnt_reg + 5'h1;
          if (cnt_reg == OPC_LAST) begin
            cmd_reg    <= op;
            cnt_reg    <= 5'h0;
            beat_reg   <= 3'h0;
            alanes_reg <= 3'h1;
            lanes_reg  <= 3'h1;
            alast_reg  <= ADDR_BITS - 5'h1;
            dlast_reg  <= DUMMY_FAST - 5'h1; // see RULE1
            phase_reg  <= PH_IGNORE;
            stat_reg   <= {1'b0, prot_s, wel_s, busy_s};
            unique case (op)
              OPC_FAST_READ: if (!busy_s) phase_reg <= PH_ADDR; // see RULE22
              OPC_DUAL_OUT: if (!busy_s) begin
                phase_reg <= PH_ADDR;
                lanes_reg <= 3'h2; // see RULE2
              end
              OPC_QUAD_OUT: if (!busy_s && qe_s) begin // see RULE4
                phase_reg <= PH_ADDR;
                lanes_reg <= 3'h4;
              end
              OPC_DUAL_IO: if (!busy_s) begin // see RULE6
                phase_reg  <= PH_ADDR;
                alanes_reg <= 3'h2;
                lanes_reg  <= 3'h2;
                alast_reg  <= (ADDR_BITS >> 1) - 5'h1;
                dlast_reg  <= DUMMY_IO - 5'h1;
              end
              OPC_QUAD_IO: if (!busy_s && qe_s) begin // see RULE25
                phase_reg  <= PH_ADDR;
                alanes_reg <= 3'h4;
                lanes_reg  <= 3'h4;
                alast_reg  <= (ADDR_BITS >> 2) - 5'h1;
                dlast_reg  <= DUMMY_IO - 5'h1; // see RULE7
              end
              OPC_SET_WRAP:  phase_reg <= PH_ADDR;
              OPC_PAGE_PROG: if (!busy_s) phase_reg <= PH_ADDR;
              OPC_RD_STATUS: phase_reg <= PH_STAT; // see RULE18
              default: phase_reg <= PH_IGNORE;
            endcase
          end
        end
        PH_ADDR: begin
          sh_reg  <= sh_next;
          cnt_reg <= cnt_reg + 5'h1;
          if (cnt_reg == alast_reg) begin
            addr_reg <= sh_next;
            cnt_reg  <= 5'h0;
            pidx_reg <= sh_next[7:0];
            if (cmd_reg == OPC_SET_WRAP) phase_reg <= PH_WRAPB;
            else if (cmd_reg == OPC_PAGE_PROG) phase_reg <= PH_PROG;
            else phase_reg <= PH_DUMMY;
          end
        end
        PH_DUMMY: begin
          // inputs ignored, lines left undriven, see RULE1
          cnt_reg <= cnt_reg + 5'h1;
          if (cnt_reg == dlast_reg) phase_reg <= PH_DATA;
        end
        PH_DATA: begin
          beat_reg <= beat_reg + 3'h1;
          if (beat_reg == last_beat(lanes_reg)) begin
            beat_reg <= 3'h0;
            // see RULE21 RULE10 RULE11
            addr_reg <= next_addr(addr_reg,
                                  cmd_reg == OPC_QUAD_IO && !wrap_s[WRAP_DIS],
                                  wrap_s[2:1]);
          end
        end
        PH_STAT: begin
          beat_reg <= beat_reg + 3'h1;
          if (beat_reg == 3'h7) stat_reg <= {1'b0, prot_s, wel_s, busy_s};
        end
        PH_PROG: begin
          sh_reg   <= {sh_reg[22:0], io_in[0]};
          beat_reg <= beat_reg + 3'h1;
          if (beat_reg == 3'h7) pidx_reg <= pidx_reg + 8'h1; // see RULE14
        end
        PH_WRAPB: begin
          sh_reg  <= {sh_reg[22:0], io_in[0]};
          cnt_reg <= cnt_reg + 5'h1;
          if (cnt_reg == OPC_LAST) begin
            wrapb_reg <= op[6:4]; // bit 7 and low nibble dropped, see RULE8
            phase_reg <= PH_IGNORE;
          end
        end
        PH_IGNORE: cnt_reg <= cnt_reg;
      endcase
    end
  end

  // page buffer fill; a wrapped index overwrites, see RULE14
  // mask kept while busy: the running program cycle still reads it
  always_ff @(posedge sck_in) begin
    if (live_reg && phase_reg == PH_OPC && cnt_reg == OPC_LAST &&
        op == OPC_PAGE_PROG && !busy_s) begin
      pmask_reg <= '0;
    end else if (live_reg && phase_reg == PH_PROG && beat_reg == 3'h7) begin
      pbuf[pidx_reg]      <= op;
      pmask_reg[pidx_reg] <= 1'b1;
    end
  end

  // data lines change on falling sck
  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      out_reg <= 4'h0;
      oe_reg  <= 4'h0;
    end else if (phase_reg == PH_DATA) begin
      {oe_reg, out_reg} <= out_bits(mem[addr_reg[MEM_ADDR_BITS-1:0]],
                                    beat_reg, lanes_reg); // see RULE24
    end else if (phase_reg == PH_STAT) begin
      {oe_reg, out_reg} <= out_bits(stat_reg, beat_reg, 3'h1);
    end else begin
      oe_reg <= 4'h0;
    end
  end

  assign {data_line_3_out, data_line_2_out,
          data_line_1_out, data_line_0_out} = out_reg;
  assign {data_line_3_oe_out, data_line_2_oe_out,
          data_line_1_oe_out, data_line_0_oe_out} = oe_reg;

  // frame end seen in the core domain
  logic        cs_q;
  logic        tog_q;
  logic [2:0]  res_q;       // commit code as plain bits from the sync
  logic [2:0]  wrapb_q;
  logic [15:0] page_q;
  logic        act;
  logic        prot;

  pin_sync3 #(
    .W    (24),
    .INIT (24'h800000)
  ) u_frame_sync (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .ce_in   (ce_in),
    .d_in    ({cs_n_in, tog_reg, res_reg, wrapb_reg, addr_reg[23:8]}),
    .q_out   ({cs_q, tog_q, res_q, wrapb_q, page_q})
  );

  assign act  = cs_q && !cs_prev_reg && (tog_q != tog_seen_reg);
  assign prot = is_protected(page_q, protect_complement_bit_in,
                             protect_granularity_bit_in,
                             protect_top_bottom_bit_in,
                             {protect_range_bit2_in, protect_range_bit1_in,
                              protect_range_bit0_in}) ||
                block_lock_in[page_q[15:8]];

  // frame bookkeeping
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cs_prev_reg  <= 1'b1;
      tog_seen_reg <= 1'b0;
    end else if (ce_in) begin
      cs_prev_reg <= cs_q;
      if (act) tog_seen_reg <= tog_q;
    end
  end

  // write enable latch; frames change it only while not busy
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wel_reg <= 1'b0;
    end else if (ce_in) begin
      if (st_reg == ST_PROG && cnt_core_reg == 16'(PROG_CYCLES - 1))
        wel_reg <= 1'b0; // see RULE19
      else if (act && !busy_reg && res_q == RES_WREN)
        wel_reg <= 1'b1; // see RULE23
      else if (act && !busy_reg && res_q == RES_WRDI)
        wel_reg <= 1'b0;
    end
  end

  // wrap setting, held until the next setup frame
  always_ff @(posedge clk_in) begin
    if (srst_in) wrap_reg <= WRAP_RESET; // see RULE12
    else if (ce_in && act && !busy_reg && res_q == RES_WRAP)
      wrap_reg <= wrapb_q; // see RULE9 RULE11
  end

  // self-timed program cycle; flash bits only go from one to zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_reg       <= ST_IDLE;
      busy_reg     <= 1'b0;
      cnt_core_reg <= 16'h0;
      ppage_reg    <= 16'h0;
    end else if (ce_in) begin
      unique case (st_reg)
        ST_IDLE: if (act && res_q == RES_PROG && wel_reg && !busy_reg &&
                     !prot) begin // see RULE13 RULE20
          st_reg       <= ST_PROG;
          busy_reg     <= 1'b1; // see RULE17
          cnt_core_reg <= 16'h0;
          ppage_reg    <= page_q;
        end
        ST_PROG: begin
          cnt_core_reg <= cnt_core_reg + 16'h1;
          if (cnt_core_reg < 16'(PAGE_BYTES) &&
              pmask_reg[cnt_core_reg[7:0]])
            mem[{ppage_reg[3:0], cnt_core_reg[7:0]}] <=
              mem[{ppage_reg[3:0], cnt_core_reg[7:0]}] &
              pbuf[cnt_core_reg[7:0]];
          if (cnt_core_reg == 16'(PROG_CYCLES - 1)) begin
            st_reg   <= ST_IDLE;
            busy_reg <= 1'b0; // see RULE17
          end
        end
      endcase
    end
  end

  assign busy_out               = busy_reg;
  assign write_enable_latch_out = wel_reg;
  assign wrap_disable_bit_out   = wrap_reg[WRAP_DIS];
  assign wrap_length_field_out  = wrap_reg[2:1];

  // checks, core domain
  sequence s_prog_start;
    $rose(busy_reg);
  endsequence

  AST_WRAP_RESET: assert property (@(posedge clk_in) // see RULE12
    srst_in |=> wrap_disable_bit_out)
    else $error("wrap not disabled after reset");
  AST_BUSY_HOLD: assert property (@(posedge clk_in) // see RULE17
    disable iff (srst_in) s_prog_start |-> busy_out [*8])
    else $error("busy dropped early");
  AST_WEL_CLR: assert property (@(posedge clk_in) // see RULE19
    disable iff (srst_in) $fell(busy_reg) |-> !wel_reg)
    else $error("latch kept after program");
  AST_PROG_WEL: assert property (@(posedge clk_in) // see RULE13
    disable iff (srst_in) s_prog_start |-> $past(wel_reg))
    else $error("program started without latch");
  AST_PROG_PROT: assert property (@(posedge clk_in) // see RULE20
    disable iff (srst_in) s_prog_start |-> !$past(prot))
    else $error("protected page programmed");

  // checks, link domain
  AST_QUAD_GATE: assert property (@(posedge sck_in) // see RULE4
    disable iff (cs_n_in) phase_reg == PH_DATA && lanes_reg == 3'h4
      |-> qe_s)
    else $error("quad read without quad enable");
  AST_DUMMY_FLOAT: assert property (@(posedge sck_in) // see RULE1
    disable iff (cs_n_in) phase_reg == PH_DUMMY |-> oe_reg == 4'h0)
    else $error("lines driven during dummies");
  AST_READ_BUSY: assert property (@(posedge sck_in) // see RULE22
    disable iff (cs_n_in) live_reg && phase_reg == PH_OPC &&
      cnt_reg == OPC_LAST && busy_s && op == OPC_FAST_READ
      |=> phase_reg == PH_IGNORE)
    else $error("read taken while busy");
endmodule

//--- spi_host_model.sv
// spi host model: chip select, serial clock and four data lines
// assumes the device launches data on falling clock edges
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic [3:0] dev_out_in,
  input  wire logic [3:0] dev_oe_in,
  output logic            sck_out,
  output logic            cs_n_out,
  output logic [3:0]      line_out
);
  logic [3:0] drv_reg = '0;  // host value per line
  logic [3:0] hoe_reg = '0;  // host enable per line
  logic       junk_reg = 0;  // free lines toggle, never hold a value
  logic       seen_oe;       // device drove within the frame
  initial sck_out = 1'b0;    // clock stands still between frames
  initial #1 cs_n_out = 1'b1; // a real rising edge clears frame state
  always @(posedge sck_out) junk_reg <= ~junk_reg;
  // device first, then host, else noise
  always_comb
    for (int i = 0; i < 4; i++)
      line_out[i] = dev_oe_in[i] ? dev_out_in[i]
                  : hoe_reg[i] ? drv_reg[i] : junk_reg ^ i[0];
  // n clocks on w lanes, msb first; drv low frees the lines
  task automatic shift(input int w, n, input logic [71:0] tx,
                       input bit drv, output logic [15:0] rx);
    rx = '0;
    for (int c = n - 1; c >= 0; c--) begin
      hoe_reg = drv ? 4'((1 << w) - 1) : 4'h0;
      drv_reg = 4'(tx >> (c * w));
      #15 sck_out = 1'b1;
      seen_oe |= |dev_oe_in;
      rx = (rx << w) | (w == 1 ? 16'(line_out[1])
                                : 16'(line_out & 4'((1 << w) - 1)));
      #15 sck_out = 1'b0;
    end
    hoe_reg = 4'h0;
  endtask
  // select low, then the opcode on line 0
  task automatic open_frame(input logic [7:0] op);
    logic [15:0] rx;
    cs_n_out = 1'b0;
    seen_oe = 1'b0;
    #15 shift(1, 8, 72'(op), 1'b1, rx);
  endtask
  // rise at once, even mid-byte, then keep the high time
  task automatic close_frame;
    cs_n_out = 1'b1;
    #1000;
  endtask
endmodule

//--- testbench.sv
// self-checking bench for flash_cmd_core driven by spi_host_model
// assumes a 10 MHz core clock and a 30 ns host serial clock
`timescale 1ns/1ns
module testbench;
  import flash_cmd_pkg::*;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b0; // raised at 2 ns so its edge is seen
  logic        qe = 1'b0;  // quad enable level
  logic [5:0]  prot = '0;  // {cmp, sec, tb, bp2, bp1, bp0}
  logic [255:0] lock = '0; // per-block locks
  logic        sck, cs_n, busy, write_enable_latch, wdis;
  logic [1:0]  wlen;
  logic [3:0]  line, dout, doe;
  logic [15:0] rx;         // data the host saw last
  logic [39:0] rows [7];   // {wrap byte, opcode, address, data}
  int          err_total = 0;
  int          checked = 0;
  always #50 clk_in = ~clk_in;
  spi_host_model host (.dev_out_in(dout), .dev_oe_in(doe),
    .sck_out(sck), .cs_n_out(cs_n), .line_out(line));
  flash_cmd_core dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
    .sck_in(sck), .cs_n_in(cs_n), .quad_enable_bit_in(qe),
    .data_line_0_in(line[0]), .data_line_0_out(dout[0]),
    .data_line_0_oe_out(doe[0]), .data_line_1_in(line[1]),
    .data_line_1_out(dout[1]), .data_line_1_oe_out(doe[1]),
    .data_line_2_in(line[2]), .data_line_2_out(dout[2]),
    .data_line_2_oe_out(doe[2]), .data_line_3_in(line[3]),
    .data_line_3_out(dout[3]), .data_line_3_oe_out(doe[3]),
    .protect_complement_bit_in(prot[5]),
    .protect_granularity_bit_in(prot[4]),
    .protect_top_bottom_bit_in(prot[3]), .protect_range_bit2_in(prot[2]),
    .protect_range_bit1_in(prot[1]), .protect_range_bit0_in(prot[0]),
    .block_lock_in(lock), .busy_out(busy),
    .write_enable_latch_out(write_enable_latch), .wrap_disable_bit_out(wdis),
    .wrap_length_field_out(wlen));
  task automatic chk(input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic one_byte(input logic [7:0] op);
    host.open_frame(op);
    host.close_frame;
  endtask
  // 24 ignored bits, then the setting byte
  task automatic set_wrap(input logic [7:0] w);
    host.open_frame(OPC_SET_WRAP);
    host.shift(1, 32, 72'(w), 1'b1, rx);
    host.close_frame;
  endtask
  // nine bytes from 0xf8: the last one wraps onto 0x00
  task automatic page_write(input int n);
    host.open_frame(OPC_PAGE_PROG);
    host.shift(1, 24, 72'hf8, 1'b1, rx);
    host.shift(1, n, 72'h01_02_04_08_10_20_40_80_7e, 1'b1, rx);
    host.close_frame;
  endtask
  // lanes follow the opcode; two data bytes read back
  task automatic read2(input logic [7:0] op, input logic [23:0] a);
    int aw;
    int dw;
    aw = (op == OPC_DUAL_IO) ? 2 : (op == OPC_QUAD_IO) ? 4 : 1;
    dw = (op == OPC_FAST_READ) ? 1 : (aw == 4 || op == OPC_QUAD_OUT) ? 4 : 2;
    host.open_frame(op);
    host.shift(aw, 24 / aw, 72'(a), 1'b1, rx);
    host.shift(1, aw > 1 ? 4 : 8, 72'h0, 1'b0, rx);
    host.shift(dw, 16 / dw, 72'h0, 1'b0, rx);
    host.close_frame;
  endtask
  task automatic status;
    host.open_frame(OPC_RD_STATUS);
    host.shift(1, 8, 72'h0, 1'b0, rx);
    host.close_frame;
  endtask
  // hang guard: whole run needs about 0.5 ms
  initial begin
    #3000000;
    err_total++;
    wrap_up;
  end
  // main sequence
  initial begin
    rows = '{40'h9f_0b_fe_4080, 40'hff_3b_f8_0102, 40'h1f_6b_fc_1020,
             40'h5f_bb_fa_0408, 40'h8f_eb_ff_8001, 40'h2f_eb_fe_4080,
             40'h4e_0b_00_7eff};
    #2 srst_in = 1'b1;
    repeat (6) @(posedge clk_in);
    #2 srst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    chk(16'({busy, write_enable_latch, wdis, wlen}), 16'h4);
    page_write(72);
    chk(16'(busy), 16'h0);
    one_byte(OPC_WR_EN);
    chk(16'(write_enable_latch), 16'h1);
    one_byte(OPC_WR_DIS);
    chk(16'(write_enable_latch), 16'h0);
    one_byte(OPC_WR_EN);
    @(posedge clk_in) #2 prot = 6'h07; // whole array protected
    page_write(72);
    chk(16'(busy), 16'h0);
    @(posedge clk_in) #2 {prot, lock[0]} = 7'h01; // block lock only
    page_write(72);
    chk(16'(busy), 16'h0);
    @(posedge clk_in) #2 lock[0] = 1'b0;
    page_write(71); // select rises one bit short
    chk(16'(busy), 16'h0);
    one_byte(OPC_WR_EN);
    page_write(72);
    chk(16'(busy), 16'h1);
    read2(OPC_FAST_READ, 24'hf8);
    chk(16'(host.seen_oe), 16'h0);
    status;
    chk(16'(rx[1:0]), 16'h3);
    for (int i = 0; i < 5000 && busy === 1'b1; i++) #100;
    chk(16'({busy, write_enable_latch}), 16'h0);
    @(posedge clk_in) #2 qe = 1'b1;
    // unerased cells read unknown: ones in data are not checked
    foreach (rows[i]) begin
      set_wrap(rows[i][39:32]);
      chk(16'({wlen, wdis}), 16'(rows[i][38:36]));
      read2(rows[i][31:24], 24'(rows[i][23:16]));
      chk(rx | rows[i][15:0], rows[i][15:0]);
    end
    @(posedge clk_in) #2 qe = 1'b0;
    read2(OPC_QUAD_OUT, 24'hf8);
    chk(16'(host.seen_oe), 16'h0);
    read2(OPC_QUAD_IO, 24'hf8);
    chk(16'(host.seen_oe), 16'h0);
    set_wrap(8'h00);
    chk(16'(wdis), 16'h0);
    @(posedge clk_in) #2 srst_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #2 srst_in = 1'b0;
    chk(16'({wdis, wlen}), 16'h4);
    wrap_up;
  end
endmodule
